// ==== rtl/tolft_top.sv ====
// framer, deframer and timing selection for a two-channel optical link
`timescale 1ns/1ps

module tolft_chan (
    input  wire logic i_mclk,
    input  wire logic i_sys_rst,
    input  wire logic i_rx_lclk,
    input  wire logic i_rx_dat,
    input  wire logic i_timing_int,
    input  wire logic [7:0] i_tx_byte,
    input  wire logic i_tx_vld,
    output logic      o_tx_rdy,
    output logic      o_tx_dat,
    output logic      o_tx_stb,
    output logic [7:0] o_rx_byte,
    output logic      o_rx_vld,
    output logic      o_rx_lock,
    output logic      o_rx_loa,
    output logic      o_line_ok,
    output logic      o_tx_from_line
);

    localparam int        BCNT_W = tolft_pkg::BCNT_W;
    localparam int        LOS_W  = tolft_pkg::LOS_W;
    localparam int        ACC_W  = tolft_pkg::ACC_W;

    // ****************************************************************
    // link domain: reset crossing
    // ****************************************************************
    logic [2:0]           lrst_r;
    logic                 lrst;
    logic                 lrst_req_r;
    logic [2:0]           lack_s_r;

    // reset request held until the link side echoes it; covers a stopped line clock
    always_ff @(posedge i_mclk) begin
        lack_s_r <= {lack_s_r[1:0], lrst_r[2]};
        if (i_sys_rst) begin
            lrst_req_r <= 1'b1;
        end else if (lack_s_r[1] && lack_s_r[2]) begin
            lrst_req_r <= 1'b0;
        end
    end

    always_ff @(posedge i_rx_lclk) begin
        lrst_r <= {lrst_r[1:0], lrst_req_r};
    end
    assign lrst = lrst_r[1] | lrst_r[2];

    // ****************************************************************
    // link domain: alignment hunt and payload extraction
    // ****************************************************************
    tolft_pkg::tolft_align_t st_r;
    logic [7:0]           sh_r;
    logic [7:0]           sh_nxt;
    logic [BCNT_W-1:0]    bcnt_r;
    logic [BCNT_W-1:0]    bcnt_nxt;
    logic [1:0]           hits_r;
    logic [1:0]           miss_r;
    logic [7:0]           lbyte_r;
    logic                 ltog_r;
    logic                 llock_r;

    assign sh_nxt   = {sh_r[6:0], i_rx_dat};
    assign bcnt_nxt = bcnt_r + 8'h01;

    always_ff @(posedge i_rx_lclk) begin
        sh_r <= lrst ? 8'h00 : sh_nxt;
    end

    always_ff @(posedge i_rx_lclk) begin
        if (lrst) begin
            st_r   <= tolft_pkg::TOLFT_HUNT;
            bcnt_r <= 8'h00;
            hits_r <= 2'h0;
            miss_r <= 2'h0;
        end else begin
            bcnt_r <= bcnt_nxt;
            unique case (st_r)
                tolft_pkg::TOLFT_HUNT: begin
                    if (sh_nxt == tolft_pkg::ALIGN_WORD) begin
                        bcnt_r <= tolft_pkg::ALIGN_END;
                        hits_r <= 2'h1;
                        st_r   <= tolft_pkg::TOLFT_VERIFY;
                    end
                end
                tolft_pkg::TOLFT_VERIFY: begin
                    if (bcnt_nxt == tolft_pkg::ALIGN_END) begin
                        if (sh_nxt != tolft_pkg::ALIGN_WORD) begin
                            st_r <= tolft_pkg::TOLFT_HUNT;
                        end else if (hits_r + 2'h1 == tolft_pkg::LOCK_HITS) begin
                            miss_r <= 2'h0;
                            st_r   <= tolft_pkg::TOLFT_LOCKED;
                        end else begin
                            hits_r <= hits_r + 2'h1;
                        end
                    end
                end
                tolft_pkg::TOLFT_LOCKED: begin
                    if (bcnt_nxt == tolft_pkg::ALIGN_END) begin
                        if (sh_nxt == tolft_pkg::ALIGN_WORD) begin
                            miss_r <= 2'h0;
                        end else if (miss_r + 2'h1 == tolft_pkg::LOSS_MISSES) begin
                            st_r <= tolft_pkg::TOLFT_HUNT;
                        end else begin
                            miss_r <= miss_r + 2'h1;
                        end
                    end
                end
                default: begin
                    st_r <= tolft_pkg::TOLFT_HUNT;
                end
            endcase
        end
    end

    // one payload byte per frame, only while aligned
    always_ff @(posedge i_rx_lclk) begin
        if (lrst) begin
            lbyte_r <= 8'h00;
            ltog_r  <= 1'b0;
        end else if (st_r == tolft_pkg::TOLFT_LOCKED &&
                     bcnt_nxt == tolft_pkg::PAYLOAD_END) begin
            lbyte_r <= sh_nxt;
            ltog_r  <= ~ltog_r;
        end
    end

    always_ff @(posedge i_rx_lclk) begin
        llock_r <= lrst ? 1'b0 : (st_r == tolft_pkg::TOLFT_LOCKED);
    end

    // ****************************************************************
    // system domain: crossings from the link
    // ****************************************************************
    logic [2:0]           ck_s_r;
    logic [2:0]           tg_s_r;
    logic [2:0]           lk_s_r;
    logic                 ck_f_r;
    logic                 tg_f_r;
    logic                 lk_f_r;
    logic                 ck_rise;
    logic                 tg_evt;

    always_ff @(posedge i_mclk) begin
        ck_s_r <= {ck_s_r[1:0], i_rx_lclk};
        tg_s_r <= {tg_s_r[1:0], ltog_r};
        lk_s_r <= {lk_s_r[1:0], llock_r};
    end

    assign ck_rise = (ck_s_r[1] == ck_s_r[2]) && ck_s_r[2] && !ck_f_r;
    assign tg_evt  = (tg_s_r[1] == tg_s_r[2]) && (tg_s_r[2] != tg_f_r);

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ck_f_r <= ck_s_r[2];
            tg_f_r <= 1'b0;
            lk_f_r <= 1'b0;
        end else begin
            if (ck_s_r[1] == ck_s_r[2]) begin
                ck_f_r <= ck_s_r[2];
            end
            if (tg_s_r[1] == tg_s_r[2]) begin
                tg_f_r <= tg_s_r[2];
            end
            if (lk_s_r[1] == lk_s_r[2]) begin
                lk_f_r <= lk_s_r[2];
            end
        end
    end

    // ****************************************************************
    // system domain: line timing presence
    // ****************************************************************
    logic [LOS_W-1:0]     los_cnt_r;

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            los_cnt_r <= LOS_W'(tolft_pkg::LOS_CYC);
            o_line_ok <= 1'b0;
        end else if (ck_rise) begin
            los_cnt_r <= '0;
            o_line_ok <= 1'b1;
        end else if (los_cnt_r != LOS_W'(tolft_pkg::LOS_CYC)) begin
            los_cnt_r <= los_cnt_r + LOS_W'(1);
        end else begin
            o_line_ok <= 1'b0;
        end
    end

    // ****************************************************************
    // system domain: received payload and alignment status
    // ****************************************************************
    logic                 lock_now;

    assign lock_now = lk_f_r && o_line_ok;

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_rx_byte <= 8'h00;
            o_rx_vld  <= 1'b0;
            o_rx_lock <= 1'b0;
            o_rx_loa  <= 1'b0;
        end else begin
            o_rx_vld  <= tg_evt && lock_now;
            if (tg_evt) begin
                o_rx_byte <= lbyte_r;
            end
            o_rx_lock <= lock_now;
            o_rx_loa  <= o_rx_lock && !lock_now;
        end
    end

    // ****************************************************************
    // system domain: transmit bit timing
    // ****************************************************************
    logic [ACC_W-1:0]     acc_r;
    logic [ACC_W:0]       acc_sum;
    logic                 nco_tick;
    logic                 bit_tick;

    assign acc_sum  = {1'b0, acc_r} + {1'b0, tolft_pkg::NCO_STEP};
    assign nco_tick = acc_sum >= {1'b0, tolft_pkg::NCO_MOD};

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            acc_r <= '0;
        end else if (nco_tick) begin
            acc_r <= ACC_W'(acc_sum - {1'b0, tolft_pkg::NCO_MOD});
        end else begin
            acc_r <= acc_sum[ACC_W-1:0];
        end
    end

    // loop timing follows the line clock; without it the local clock keeps sending
    assign o_tx_from_line = !i_timing_int && o_line_ok;
    assign bit_tick       = o_tx_from_line ? ck_rise : nco_tick;

    // ****************************************************************
    // system domain: transmit framer
    // ****************************************************************
    logic [BCNT_W-1:0]    tcnt_r;
    logic [7:0]           tsh_r;
    logic [7:0]           tpay_r;
    logic                 tpay_full_r;
    logic                 tx_take;
    logic                 pay_load;

    assign o_tx_rdy = !tpay_full_r;
    assign tx_take  = i_tx_vld && o_tx_rdy;
    assign pay_load = bit_tick && tcnt_r == tolft_pkg::PAYLOAD_MSB;

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            tpay_r      <= tolft_pkg::IDLE_BYTE;
            tpay_full_r <= 1'b0;
        end else if (tx_take) begin
            tpay_r      <= i_tx_byte;
            tpay_full_r <= 1'b1;
        end else if (pay_load) begin
            tpay_r      <= tolft_pkg::IDLE_BYTE;
            tpay_full_r <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            tcnt_r   <= '0;
            tsh_r    <= tolft_pkg::ALIGN_WORD;
            o_tx_dat <= tolft_pkg::IDLE_BIT;
            o_tx_stb <= 1'b0;
        end else begin
            o_tx_stb <= bit_tick;
            if (bit_tick) begin
                tcnt_r <= tcnt_r + BCNT_W'(1);
                if (tcnt_r == '0) begin
                    o_tx_dat <= tolft_pkg::ALIGN_WORD[7];
                    tsh_r    <= {tolft_pkg::ALIGN_WORD[6:0], 1'b0};
                end else if (tcnt_r == tolft_pkg::PAYLOAD_MSB) begin
                    o_tx_dat <= tpay_r[7];
                    tsh_r    <= {tpay_r[6:0], 1'b0};
                end else if (tcnt_r > tolft_pkg::PAYLOAD_END) begin
                    o_tx_dat <= tolft_pkg::IDLE_BIT;
                end else begin
                    o_tx_dat <= tsh_r[7];
                    tsh_r    <= {tsh_r[6:0], 1'b0};
                end
            end
        end
    end

endmodule

module tolft_top (
    input  wire logic       i_mclk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_ch1_rx_lclk,
    input  wire logic       i_ch2_rx_lclk,
    input  wire logic [1:0] i_rx_dat,
    input  wire logic       i_cfg_wr,
    input  wire logic [1:0] i_cfg_timing_int,
    input  wire logic [15:0] i_tx_byte,
    input  wire logic [1:0] i_tx_vld,
    output logic [1:0]      o_tx_rdy,
    output logic [1:0]      o_tx_dat,
    output logic [1:0]      o_tx_stb,
    output logic [15:0]     o_rx_byte,
    output logic [1:0]      o_rx_vld,
    output logic [1:0]      o_rx_lock,
    output logic [1:0]      o_rx_loa,
    output logic [1:0]      o_line_ok,
    output logic [1:0]      o_tx_from_line,
    output logic [1:0]      o_timing_int
);

    // ****************************************************************
    // per-channel timing selection
    // ****************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_timing_int <= {2{tolft_pkg::TOLFT_LOOP}};
        end else if (i_cfg_wr) begin
            o_timing_int <= i_cfg_timing_int;
        end
    end

    // ****************************************************************
    // channels
    // ****************************************************************
    tolft_chan u_ch1 (
        .i_mclk         (i_mclk),
        .i_sys_rst      (i_sys_rst),
        .i_rx_lclk      (i_ch1_rx_lclk),
        .i_rx_dat       (i_rx_dat[0]),
        .i_timing_int   (o_timing_int[0]),
        .i_tx_byte      (i_tx_byte[7:0]),
        .i_tx_vld       (i_tx_vld[0]),
        .o_tx_rdy       (o_tx_rdy[0]),
        .o_tx_dat       (o_tx_dat[0]),
        .o_tx_stb       (o_tx_stb[0]),
        .o_rx_byte      (o_rx_byte[7:0]),
        .o_rx_vld       (o_rx_vld[0]),
        .o_rx_lock      (o_rx_lock[0]),
        .o_rx_loa       (o_rx_loa[0]),
        .o_line_ok      (o_line_ok[0]),
        .o_tx_from_line (o_tx_from_line[0])
    );

    tolft_chan u_ch2 (
        .i_mclk         (i_mclk),
        .i_sys_rst      (i_sys_rst),
        .i_rx_lclk      (i_ch2_rx_lclk),
        .i_rx_dat       (i_rx_dat[1]),
        .i_timing_int   (o_timing_int[1]),
        .i_tx_byte      (i_tx_byte[15:8]),
        .i_tx_vld       (i_tx_vld[1]),
        .o_tx_rdy       (o_tx_rdy[1]),
        .o_tx_dat       (o_tx_dat[1]),
        .o_tx_stb       (o_tx_stb[1]),
        .o_rx_byte      (o_rx_byte[15:8]),
        .o_rx_vld       (o_rx_vld[1]),
        .o_rx_lock      (o_rx_lock[1]),
        .o_rx_loa       (o_rx_loa[1]),
        .o_line_ok      (o_line_ok[1]),
        .o_tx_from_line (o_tx_from_line[1])
    );

endmodule

// ==== include/tolft_pkg.sv ====
// constants and types for the optical teleprotection link framer
package tolft_pkg;

    // ****************************************************************
    // frame layout
    // ****************************************************************
    localparam int          FRAME_BITS   = 256;
    localparam int          FRAME_HZ     = 8000;
    localparam int          LINE_KBPS    = FRAME_BITS * FRAME_HZ / 1000;
    localparam int          BCNT_W       = 8;
    localparam logic [7:0]  ALIGN_WORD   = 8'h1b;
    localparam logic [7:0]  ALIGN_END    = 8'h07;
    localparam logic [7:0]  PAYLOAD_END  = 8'h0f;
    localparam logic [7:0]  PAYLOAD_MSB  = 8'h08;
    localparam logic [7:0]  IDLE_BYTE    = 8'hff;
    localparam logic        IDLE_BIT     = 1'b1;
    localparam logic [1:0]  LOCK_HITS    = 2'h3;
    localparam logic [1:0]  LOSS_MISSES  = 2'h3;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int          MCLK_KHZ     = 20000;
    localparam int          ACC_W        = 15;
    localparam logic [14:0] NCO_MOD      = 15'(MCLK_KHZ);
    localparam logic [14:0] NCO_STEP     = 15'(LINE_KBPS);
    localparam int          LOS_TIME_NS  = 4000;
    localparam int          LOS_CYC      = LOS_TIME_NS * (MCLK_KHZ / 1000) / 1000;
    localparam int          LOS_W        = 8;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        TOLFT_HUNT   = 2'b00,
        TOLFT_VERIFY = 2'b01,
        TOLFT_LOCKED = 2'b10
    } tolft_align_t;

    typedef enum logic {
        TOLFT_LOOP     = 1'b0,
        TOLFT_INTERNAL = 1'b1
    } tolft_timing_t;

endpackage

// ==== tb/tolft_sva.sv ====
// assertion checker on the link framer top ports
`timescale 1ns/1ps

module tolft_sva (
    input wire logic       i_mclk,
    input wire logic       i_sys_rst,
    input wire logic       i_ch1_rx_lclk,
    input wire logic       i_cfg_wr,
    input wire logic [1:0] i_cfg_timing_int,
    input wire logic [1:0] i_tx_vld,
    input wire logic [1:0] o_tx_rdy,
    input wire logic [1:0] o_tx_dat,
    input wire logic [1:0] o_tx_stb,
    input wire logic [1:0] o_rx_vld,
    input wire logic [1:0] o_rx_lock,
    input wire logic [1:0] o_rx_loa,
    input wire logic [1:0] o_line_ok,
    input wire logic [1:0] o_tx_from_line,
    input wire logic [1:0] o_timing_int
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    logic       lclk_q_r;
    logic [7:0] quiet_r;
    // mclk cycles since the last channel 1 line clock rising edge
    always_ff @(posedge i_mclk) begin
        lclk_q_r <= i_ch1_rx_lclk;
        if (i_sys_rst) begin
            quiet_r <= 8'hff;
        end else if (i_ch1_rx_lclk && !lclk_q_r) begin
            quiet_r <= 8'h00;
        end else if (quiet_r != 8'hff) begin
            quiet_r <= quiet_r + 8'h01;
        end
    end
    cfg_load_a:
        assert property (i_cfg_wr |=> o_timing_int == $past(i_cfg_timing_int))
        else $error("timing selection not loaded");
    cfg_hold_a:
        assert property (!i_cfg_wr |=> $stable(o_timing_int))
        else $error("timing selection changed without a write");
    tick_source_a:
        assert property (o_tx_from_line == (~o_timing_int & o_line_ok))
        else $error("transmit tick source wrong");
    tick_space_a:
        assert property (o_tx_stb[0] && o_timing_int[0] && $past(o_timing_int[0], 12)
            |=> !o_tx_stb[0] [*8] ##1 (o_tx_stb[0] or ##1 o_tx_stb[0]))
        else $error("internal bit ticks not 9 or 10 cycles apart");
    bit_change_a:
        assert property (o_tx_dat[0] != $past(o_tx_dat[0]) |-> o_tx_stb[0])
        else $error("line bit changed without strobe");
    rdy_take_a:
        assert property (i_tx_vld[0] && o_tx_rdy[0] |=> !o_tx_rdy[0])
        else $error("payload holder not marked full");
    loa_edge_a:
        assert property (o_rx_loa[0] |-> !o_rx_lock[0] && $past(o_rx_lock[0]))
        else $error("alignment loss without lock fall");
    vld_lock_a:
        assert property (o_rx_vld[0] |-> o_rx_lock[0])
        else $error("payload delivered while unlocked");
    line_gone_a:
        assert property (quiet_r > 8'h5f |-> !o_line_ok[0] && !o_rx_lock[0])
        else $error("line timing reported without clock");
endmodule

bind tolft_top tolft_sva u_sva (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ch1_rx_lclk(i_ch1_rx_lclk),
    .i_cfg_wr(i_cfg_wr), .i_cfg_timing_int(i_cfg_timing_int), .i_tx_vld(i_tx_vld),
    .o_tx_rdy(o_tx_rdy), .o_tx_dat(o_tx_dat), .o_tx_stb(o_tx_stb), .o_rx_vld(o_rx_vld),
    .o_rx_lock(o_rx_lock), .o_rx_loa(o_rx_loa), .o_line_ok(o_line_ok),
    .o_tx_from_line(o_tx_from_line), .o_timing_int(o_timing_int));

// ==== tb/tolft_far_end.sv ====
// far end model: line clock source and framed serial sender
`timescale 1ns/1ps

module tolft_far_end (
    input  wire logic       i_base_clk,
    input  wire logic       i_run,
    input  wire logic       i_bad,
    input  wire logic [7:0] i_byte,
    output logic            o_lclk,
    output logic            o_dat
);
    logic [2:0] div_r;
    logic [7:0] idx_r;
    initial begin
        o_lclk = 1'b0;
        o_dat = 1'b1;
        div_r = 3'h0;
        idx_r = 8'h00;
    end
    // alignment word, payload byte msb first, idle ones
    function automatic logic bit_at(input logic [7:0] i);
        if (i < 8'h08) begin
            return tolft_pkg::ALIGN_WORD[~i[2:0]] ^ i_bad;
        end
        if (i < 8'h10) begin
            return i_byte[~i[2:0]];
        end
        return 1'b1;
    endfunction
    // far end is the timing source; clock stands still when stopped
    always @(posedge i_base_clk) begin
        if (!i_run) begin
            o_lclk <= 1'b0;
            div_r <= 3'h0;
            o_dat <= ~o_dat;
        end else if (div_r == 3'h4) begin
            div_r <= 3'h0;
            o_lclk <= ~o_lclk;
            if (o_lclk) begin
                o_dat <= bit_at(idx_r);
                idx_r <= idx_r + 8'h01;
            end
        end else begin
            div_r <= div_r + 3'h1;
        end
    end
endmodule

// ==== tb/tolft_top_bench.sv ====
// self-checking bench for the two-channel link framer
`timescale 1ns/1ps

module tolft_top_bench;
    logic i_mclk, i_sys_rst, base_clk, l1, l2, i_cfg_wr, b;
    logic [1:0]  i_rx_dat, i_cfg_timing_int, i_tx_vld, run, bad;
    logic [15:0] i_tx_byte, fbyte;
    logic [1:0]  o_tx_rdy, o_tx_dat, o_tx_stb, o_rx_vld, o_rx_lock, o_rx_loa;
    logic [1:0]  o_line_ok, o_tx_from_line, o_timing_int;
    logic [15:0] o_rx_byte;
    logic [7:0]  sh;
    int          n_errors, comparisons, cyc, t0, n1, n2;

    tolft_top uut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ch1_rx_lclk(l1),
        .i_ch2_rx_lclk(l2), .i_rx_dat(i_rx_dat), .i_cfg_wr(i_cfg_wr),
        .i_cfg_timing_int(i_cfg_timing_int), .i_tx_byte(i_tx_byte), .i_tx_vld(i_tx_vld),
        .o_tx_rdy(o_tx_rdy), .o_tx_dat(o_tx_dat), .o_tx_stb(o_tx_stb),
        .o_rx_byte(o_rx_byte), .o_rx_vld(o_rx_vld), .o_rx_lock(o_rx_lock),
        .o_rx_loa(o_rx_loa), .o_line_ok(o_line_ok), .o_tx_from_line(o_tx_from_line),
        .o_timing_int(o_timing_int));
    tolft_far_end far1 (.i_base_clk(base_clk), .i_run(run[0]), .i_bad(bad[0]),
        .i_byte(fbyte[7:0]), .o_lclk(l1), .o_dat(i_rx_dat[0]));
    tolft_far_end far2 (.i_base_clk(base_clk), .i_run(run[1]), .i_bad(bad[1]),
        .i_byte(fbyte[15:8]), .o_lclk(l2), .o_dat(i_rx_dat[1]));

    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    initial begin
        base_clk = 1'b0;
        #7;
        forever #24 base_clk = ~base_clk;
    end
    always @(posedge i_mclk) cyc++;

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic cfg(input logic [1:0] v);
        @(negedge i_mclk);
        i_cfg_timing_int = v;
        i_cfg_wr = 1'b1;
        @(negedge i_mclk);
        i_cfg_wr = 1'b0;
        chk(o_timing_int === v, "timing selection");
    endtask
    // next channel 1 line bit, taken in its strobe cycle
    task automatic get_bit();
        repeat (12) begin
            @(negedge i_mclk);
            if (o_tx_stb[0] === 1'b1) break;
        end
        b = o_tx_dat[0];
        sh = {sh[6:0], b};
    endtask
    task automatic sync_word();
        repeat (600) begin
            get_bit();
            if (sh === tolft_pkg::ALIGN_WORD) break;
        end
        t0 = cyc;
    endtask
    // payload slot, idle ones, then next alignment word 256 bits on
    task automatic frame(input logic [7:0] exp);
        n1 = 0;
        repeat (8) get_bit();
        chk(sh === exp, "payload slot");
        repeat (240) begin
            get_bit();
            n1 += (b === 1'b1);
        end
        chk(n1 == 240, "idle bits");
        repeat (8) get_bit();
        chk(sh === tolft_pkg::ALIGN_WORD, "frame length");
        chk(cyc - t0 >= 2499 && cyc - t0 <= 2501, "frame rate");
        t0 = cyc;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        chk(o_timing_int === 2'b00 && o_tx_rdy === 2'b11, "reset state");
    endtask
    task automatic t_rx();
        repeat (12000) begin
            @(negedge i_mclk);
            if (o_rx_lock[0] === 1'b1) break;
        end
        chk(o_rx_lock === 2'b01 && o_line_ok === 2'b01, "lock");
        repeat (3000) begin
            @(negedge i_mclk);
            if (o_rx_vld[0] === 1'b1) break;
        end
        chk(o_rx_byte[7:0] === 8'hc3, "received payload");
    endtask
    task automatic t_rate();
        cfg(2'b00);
        chk(o_tx_from_line === 2'b01, "tick source");
        n1 = 0;
        n2 = 0;
        repeat (4800) begin
            @(negedge i_mclk);
            n1 += (o_tx_stb[0] === 1'b1);
            n2 += (o_tx_stb[1] === 1'b1);
        end
        chk(n1 >= 499 && n1 <= 501, "loop rate");
        chk(n2 >= 491 && n2 <= 492, "fallback rate");
    endtask
    task automatic t_modes();
        cfg(2'b10);
        chk(o_tx_from_line === 2'b01, "per channel source");
        cfg(2'b01);
        chk(o_tx_from_line === 2'b00, "internal source");
    endtask
    task automatic t_frame();
        repeat (20) @(negedge i_mclk);
        sync_word();
        i_tx_byte = 16'h965a;
        i_tx_vld = 2'b11;
        @(negedge i_mclk);
        i_tx_vld = 2'b00;
        chk(o_tx_rdy === 2'b00, "holder full");
        // byte taken just after the alignment word fills this frame's payload slot
        frame(8'h5a);
        chk(o_tx_rdy[0] === 1'b1, "holder emptied");
        frame(tolft_pkg::IDLE_BYTE);
    endtask
    task automatic t_loss();
        bad[0] = 1'b1;
        n1 = 0;
        repeat (12000) begin
            @(negedge i_mclk);
            if (o_rx_loa[0] === 1'b1) break;
        end
        chk(o_rx_loa[0] === 1'b1 && o_rx_lock[0] === 1'b0, "alignment loss");
        bad[0] = 1'b0;
        run[0] = 1'b0;
        repeat (100) @(negedge i_mclk);
        chk(o_line_ok[0] === 1'b0, "line timing gone");
    endtask

    task automatic end_of_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge i_mclk);
        n_errors++;
        end_of_test();
    end
    initial begin
        {i_sys_rst, i_cfg_wr, i_cfg_timing_int, i_tx_vld} = 6'h20;
        {run, bad, i_tx_byte, fbyte, sh, cyc} = '0;
        fbyte = 16'h3cc3;
        repeat (10) @(negedge i_mclk);
        i_sys_rst = 1'b0;
        run = 2'b01;
        t_reset();
        t_rx();
        t_rate();
        t_modes();
        t_frame();
        t_loss();
        end_of_test();
    end
endmodule
